/* File: rtl/reset_source_pkg.sv */
// Purpose: constants for the reset source controller
// Assumes: 8-bit registers on a plain strobe port, 100 MHz clock
// Notes: offsets are byte addresses of the register port
// Operation
// - seven reset causes: external pin, power-on and five internal ones
// - staging bit 0 set disables the external pin reset
// - staged pin disable becomes active only after key 0xB2
// - key 0xB2 commits pin disable, 0xD4 options, 0x71 flag clear
// - only power-on clears committed disable; any reset clears staged values
// - staging bits 7..3 read zero, bits 2..0 read-write reset zero
// - key address reads committed state: bit 0 disable, bits 1..2 options
// - sticky cause flags: watchdog, clock, detect1, detect2, trimming
// - status bit 5 shows abnormal trimming data
// - flags cleared only by power-on, pin reset or keyed clear
// - clear request bit 7 then key 0x71 zeroes flags, request self-clears
// - cause register bits 7 and 6 read zero; bit 7 write-only
// - any reset holds warm-up counter, processor and peripherals
// - after release warm-up counts the high-frequency oscillator clock
// - trimming data loads from non-volatile store during warm-up
// - after warm-up the processor fetches the vector at 0xFFFE/0xFFFF
// - a reset during warm-up restarts the warm-up count
// - all causes reset alike except cause-specific registers and detectors
// - power-on and pin reset are ORed
// - only pin or power-on reset disables the voltage detectors
package reset_source_pkg;
   localparam logic [15:0] ADDR_CAUSE = 16'h0FCC;
   localparam logic [15:0] ADDR_STAGE = 16'h0FDE;
   localparam logic [15:0] ADDR_KEY = 16'h0FDF;
   localparam logic [7:0] KEY_PIN_DISABLE = 8'hB2;
   localparam logic [7:0] KEY_OPTIONS = 8'hD4;
   localparam logic [7:0] KEY_FLAG_CLEAR = 8'h71;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int STAGE_BITS = 3;
   localparam int BIT_PIN_DIS = 0;
   localparam int BIT_OPT_A = 1;
   localparam int BIT_OPT_B = 2;
   localparam int BIT_FCLR = 7;
   localparam int BIT_TRIM_STAT = 5;
   localparam int CAUSE_BITS = 5;
   localparam logic [15:0] RESET_VECTOR_LO = 16'hFFFE;
   localparam logic [15:0] RESET_VECTOR_HI = 16'hFFFF;
   localparam int WARMUP_CYCLES = 256;
   localparam int TRIM_WORDS = 4;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [2:0] {
      ST_RESET,
      ST_WARMUP,
      ST_RUN
   } phase_t;
endpackage

/* File: rtl/reset_cause_if.sv */
// Purpose: cause and reset bundle between sync stage and controller
// Assumes: single clock
// Notes: causes are already synchronous here
`timescale 1ns/1ps
`default_nettype none
interface reset_cause_if;
   logic pin_req;
   logic por_req;
   logic [reset_source_pkg::CAUSE_BITS-1:0] int_req;
   modport sync (output pin_req, output por_req, output int_req);
   modport ctrl (input pin_req, input por_req, input int_req);
endinterface
`default_nettype wire

/* File: rtl/reset_cause_sync.sv */
// Purpose: two-flop synchronisers for every reset cause
// Assumes: cause inputs are asynchronous levels, active high
// Notes: first flop is read only by the second
`timescale 1ns/1ps
`default_nettype none
module reset_cause_sync
   import reset_source_pkg::*;
#(
   parameter int WIDTH = CAUSE_BITS + 2
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] raw_i,
   reset_cause_if.sync causes
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   // two stages so a cause changing near the edge cannot go metastable
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= raw_i;
         sync_reg <= meta_reg;
      end
   end
   assign causes.pin_req = sync_reg[0];
   assign causes.por_req = sync_reg[1];
   assign causes.int_req = sync_reg[WIDTH-1:2];
endmodule
`default_nettype wire

/* File: rtl/reset_source_controller.sv */
// Purpose: merges reset causes, runs post-reset warm-up, holds keyed registers
// Assumes: CLK_I 100 MHz; RESETN_I is the power-on reset, active low
// Notes: internal causes arrive as active-high levels and are synchronised here
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller
   import reset_source_pkg::*;
#(
   parameter int WARMUP_LEN = WARMUP_CYCLES,
   parameter int TRIM_LEN = TRIM_WORDS
)(
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic EXT_RESET_N_I,
   input wire logic WATCHDOG_RESET_I,
   input wire logic CLOCK_FAULT_RESET_I,
   input wire logic VOLT_DETECT1_RESET_I,
   input wire logic VOLT_DETECT2_RESET_I,
   input wire logic TRIM_FAULT_RESET_I,
   input wire logic TRIM_ABNORMAL_I,
   input wire logic [7:0] TRIM_DATA_I,
   input wire logic [15:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   output logic SYS_RESET_O,
   output logic WARMUP_ACTIVE_O,
   output logic CPU_RUN_O,
   output logic [15:0] VECTOR_ADDR_O,
   output logic TRIM_LOAD_O,
   output logic [7:0] TRIM_LADDER_O,
   output logic VOLT_DETECT_DISABLE_O,
   output logic OPTION_A_O,
   output logic OPTION_B_O
);
   import reset_source_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // cause synchronisation
   reset_cause_if causes ();
   logic [CAUSE_BITS+1:0] raw_causes;
   // order: pin, power-on, watchdog, clock, detect1, detect2, trim
   assign raw_causes = {TRIM_FAULT_RESET_I, VOLT_DETECT2_RESET_I, VOLT_DETECT1_RESET_I,
                        CLOCK_FAULT_RESET_I, WATCHDOG_RESET_I, 1'b0, ~EXT_RESET_N_I};

   reset_cause_sync #(.WIDTH(CAUSE_BITS + 2)) u_sync (
      .clk_i(CLK_I),
      .rst_n_i(RESETN_I),
      .raw_i(raw_causes),
      .causes(causes)
   );

   ////////////////////////////////////////////////////////////////////////
   // cause merge
   logic pin_disable_reg;
   logic pin_reset;
   logic any_internal;
   logic any_reset;
   logic por_seen_reg;
   // power-on pulse seen for one cycle after release so registers can see it
   assign pin_reset = causes.pin_req & ~pin_disable_reg;
   assign any_internal = |causes.int_req;
   // power-on and pin are ORed; reset lasts while any internal cause is held, or the pin while its disable is not committed
   assign any_reset = por_seen_reg | pin_reset | any_internal;

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         por_seen_reg <= 1'b1;
      else
         por_seen_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // register port decode
   logic wr_cause;
   logic wr_stage;
   logic wr_key;
   logic key_pin;
   logic key_opt;
   logic key_clr;
   assign wr_cause = WR_I && (ADDR_I == ADDR_CAUSE);
   assign wr_stage = WR_I && (ADDR_I == ADDR_STAGE);
   assign wr_key = WR_I && (ADDR_I == ADDR_KEY);
   // other key values do nothing
   assign key_pin = wr_key && (WDATA_I == KEY_PIN_DISABLE);
   assign key_opt = wr_key && (WDATA_I == KEY_OPTIONS);
   assign key_clr = wr_key && (WDATA_I == KEY_FLAG_CLEAR);

   ////////////////////////////////////////////////////////////////////////
   // staging register, cleared by every reset cause
   logic [STAGE_BITS-1:0] stage_reg;
   logic [STAGE_BITS-1:0] stage_next;
   always_comb
   begin
      stage_next = stage_reg;
      if (any_reset)
         stage_next = '0;
      else if (wr_stage)
         stage_next = WDATA_I[STAGE_BITS-1:0];
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         stage_reg <= '0;
      else
         stage_reg <= stage_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // committed state: pin disable survives all but power-on
   logic opt_a_reg;
   logic opt_b_reg;
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         pin_disable_reg <= 1'b0;
         opt_a_reg <= 1'b0;
         opt_b_reg <= 1'b0;
      end
      else
      begin
         if (key_pin && !any_reset)
            pin_disable_reg <= stage_reg[BIT_PIN_DIS];
         // options follow the ordinary reset like the rest of the chip
         if (any_reset)
         begin
            opt_a_reg <= 1'b0;
            opt_b_reg <= 1'b0;
         end
         else if (key_opt)
         begin
            opt_a_reg <= stage_reg[BIT_OPT_A];
            opt_b_reg <= stage_reg[BIT_OPT_B];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cause flags: set from synchronised causes on the same edge that raises system reset
   logic [CAUSE_BITS-1:0] flags_reg;
   logic [CAUSE_BITS-1:0] flags_next;
   logic trim_stat_reg;
   logic fclr_reg;
   logic flag_clear;
   // keyed clear only acts when the request bit was staged
   assign flag_clear = key_clr && fclr_reg;

   always_comb
   begin
      flags_next = flags_reg;
      // pin reset wipes flags; internal causes leave them
      if (pin_reset || flag_clear)
         flags_next = '0;
      // set wins over clear so a cause in the clear cycle survives
      flags_next = flags_next | causes.int_req;
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         flags_reg <= '0;
         trim_stat_reg <= 1'b0;
         fclr_reg <= 1'b0;
      end
      else
      begin
         flags_reg <= flags_next;
         if (TRIM_ABNORMAL_I)
            trim_stat_reg <= 1'b1;
         else if (pin_reset || flag_clear)
            trim_stat_reg <= 1'b0;
         if (key_clr || any_reset)
            fclr_reg <= 1'b0;
         else if (wr_cause)
            fclr_reg <= WDATA_I[BIT_FCLR];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, data one cycle after strobe
   logic [7:0] rd_mux;
   logic [7:0] rd_cause;
   logic [7:0] rd_stage;
   logic [7:0] rd_commit;
   // bits 7 and 6 read zero, clear request is write-only
   assign rd_cause = {2'b00, trim_stat_reg, flags_reg};
   assign rd_stage = {{(8 - STAGE_BITS){1'b0}}, stage_reg};
   assign rd_commit = {5'b00000, opt_b_reg, opt_a_reg, pin_disable_reg};
   assign rd_mux = (ADDR_I == ADDR_CAUSE) ? rd_cause :
                   (ADDR_I == ADDR_STAGE) ? rd_stage :
                   (ADDR_I == ADDR_KEY) ? rd_commit : REG_RESET;

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         RDATA_O <= REG_RESET;
      else if (RD_I)
         RDATA_O <= rd_mux;
      else
         RDATA_O <= REG_RESET;
   end

   ////////////////////////////////////////////////////////////////////////
   // warm-up sequencer
   phase_t phase_reg;
   phase_t phase_next;
   logic [$clog2(WARMUP_LEN+1)-1:0] warm_cnt_reg;
   logic [$clog2(TRIM_LEN+1)-1:0] trim_idx_reg;
   logic warm_done;
   logic trim_done;
   assign warm_done = (warm_cnt_reg == ($clog2(WARMUP_LEN+1))'(WARMUP_LEN - 1));
   assign trim_done = (trim_idx_reg == ($clog2(TRIM_LEN+1))'(TRIM_LEN));

   always_comb
   begin
      phase_next = phase_reg;
      unique case (phase_reg)
         ST_RESET:
            if (!any_reset)
               phase_next = ST_WARMUP;
         ST_WARMUP:
            if (any_reset)
               phase_next = ST_RESET;
            else if (warm_done && trim_done)
               phase_next = ST_RUN;
         ST_RUN:
            if (any_reset)
               phase_next = ST_RESET;
      endcase
   end

   // counter cleared throughout reset
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         phase_reg <= ST_RESET;
         warm_cnt_reg <= '0;
         trim_idx_reg <= '0;
         TRIM_LADDER_O <= REG_RESET;
      end
      else
      begin
         phase_reg <= phase_next;
         if (phase_next != ST_WARMUP)
         begin
            warm_cnt_reg <= '0;
            trim_idx_reg <= '0;
         end
         else
         begin
            if (!warm_done)
               warm_cnt_reg <= warm_cnt_reg + 1'b1;
            if (!trim_done && phase_reg == ST_WARMUP)
            begin
               trim_idx_reg <= trim_idx_reg + 1'b1;
               TRIM_LADDER_O <= TRIM_DATA_I;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // flags latch on the same edge that phase enters reset; both lag any_reset by one cycle
   assign SYS_RESET_O = (phase_reg == ST_RESET);
   assign WARMUP_ACTIVE_O = (phase_reg == ST_WARMUP);
   assign CPU_RUN_O = (phase_reg == ST_RUN);
   assign TRIM_LOAD_O = (phase_reg == ST_WARMUP) && !trim_done;
   assign VECTOR_ADDR_O = RESET_VECTOR_LO;
   // detectors off only for power-on or pin reset
   assign VOLT_DETECT_DISABLE_O = por_seen_reg | pin_reset;
   assign OPTION_A_O = opt_a_reg;
   assign OPTION_B_O = opt_b_reg;
endmodule
`default_nettype wire

/* File: testbench/reset_source_controller_props.sv */
// Purpose: port properties of the reset source controller
// Assumes: one clock, power-on reset active low
// Notes: read data is checked in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module reset_source_props (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic WATCHDOG_RESET_I,
   input wire logic [15:0] ADDR_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic SYS_RESET_O,
   input wire logic WARMUP_ACTIVE_O,
   input wire logic CPU_RUN_O,
   input wire logic [15:0] VECTOR_ADDR_O,
   input wire logic TRIM_LOAD_O
);
   // power-on reset mutes everything, $fell needs a settled history
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   ////////////////////////////////////////
   // register read-back shapes
   chk_stage_upper_zero: assert property (RD_I && ADDR_I == 16'h0FDE |=> RDATA_O[7:3] == 5'h00)
      else $error("stage upper bits not zero");
   chk_commit_upper_zero: assert property (RD_I && ADDR_I == 16'h0FDF |=> RDATA_O[7:3] == 5'h00)
      else $error("committed upper bits not zero");
   chk_cause_top_zero: assert property (RD_I && ADDR_I == 16'h0FCC |=> RDATA_O[7:6] == 2'h0)
      else $error("cause top bits not zero");
   // sequencing of reset, warm-up and run
   chk_cause_to_reset: assert property ($rose(WATCHDOG_RESET_I) |-> ##[2:4] SYS_RESET_O)
      else $error("cause did not reset");
   chk_reset_holds_all: assert property (SYS_RESET_O |-> !CPU_RUN_O && !WARMUP_ACTIVE_O)
      else $error("run or warm-up during reset");
   chk_warmup_starts: assert property ($fell(SYS_RESET_O) |-> WARMUP_ACTIVE_O)
      else $error("warm-up not started");
   chk_warmup_bounded: assert property ($rose(WARMUP_ACTIVE_O) |-> ##[1:60] !WARMUP_ACTIVE_O)
      else $error("warm-up never ends");
   chk_trim_in_warmup: assert property (TRIM_LOAD_O |-> WARMUP_ACTIVE_O)
      else $error("trim load outside warm-up");
   chk_run_after_warm: assert property ($fell(WARMUP_ACTIVE_O) && !SYS_RESET_O |-> CPU_RUN_O)
      else $error("run missing after warm-up");
   chk_vector_fixed: assert property (CPU_RUN_O |-> VECTOR_ADDR_O == 16'hFFFE)
      else $error("wrong start vector");
   cov_cause_reset: cover property ($rose(WATCHDOG_RESET_I) ##[2:4] SYS_RESET_O);
   cov_warm_done: cover property ($fell(WARMUP_ACTIVE_O) && CPU_RUN_O);
   cov_commit_read: cover property (RD_I && ADDR_I == 16'h0FDF ##1 RDATA_O != 8'h00);
endmodule
bind reset_source_controller reset_source_props props_u (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .WATCHDOG_RESET_I(WATCHDOG_RESET_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .SYS_RESET_O(SYS_RESET_O), .WARMUP_ACTIVE_O(WARMUP_ACTIVE_O), .CPU_RUN_O(CPU_RUN_O),
   .VECTOR_ADDR_O(VECTOR_ADDR_O), .TRIM_LOAD_O(TRIM_LOAD_O));
`default_nettype wire

/* File: testbench/reset_source_controller_bench.sv */
// Purpose: register and reset sequencing bench
// Assumes: warm-up shortened to 8 cycles, trim to 2 words
// Notes: causes are held 7 cycles in hit and the pin test, 6 in the overlap test, to clear the synchronisers
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_bench;
   import reset_source_pkg::*;
   localparam int WARM = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ext_n = 1'b1;
   logic [4:0] cause = 5'h00;
   logic trim_bad = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [7:0] ladder;
   logic [15:0] vec;
   logic sys_rst, warm, run, vdis, opt_a, opt_b;
   int mismatches = 0;
   int comparisons = 0;
   int n;
   always #5 clk = ~clk;
   reset_source_controller #(.WARMUP_LEN(WARM), .TRIM_LEN(2)) dut_u (.CLK_I(clk), .RESETN_I(rst_n),
      .EXT_RESET_N_I(ext_n), .WATCHDOG_RESET_I(cause[0]), .CLOCK_FAULT_RESET_I(cause[1]),
      .VOLT_DETECT1_RESET_I(cause[2]), .VOLT_DETECT2_RESET_I(cause[3]), .TRIM_FAULT_RESET_I(cause[4]),
      .TRIM_ABNORMAL_I(trim_bad), .TRIM_DATA_I(8'h5A), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .SYS_RESET_O(sys_rst), .WARMUP_ACTIVE_O(warm), .CPU_RUN_O(run),
      .VECTOR_ADDR_O(vec), .TRIM_LOAD_O(), .TRIM_LADDER_O(ladder), .VOLT_DETECT_DISABLE_O(vdis),
      .OPTION_A_O(opt_a), .OPTION_B_O(opt_b));
   ////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // bus cycles: strobe for one cycle, data the cycle after
   // key register only ever gets whole-byte writes, never a read-back merge
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, exp}, {8'h00, rdata});
   endtask
   // bounded wait for run, a hang ends the run
   task automatic wait_run();
      n = 0;
      while (run !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 2000)
      begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic hit(input logic [4:0] c);
      @(posedge clk);
      cause <= c;
      repeat (6) @(posedge clk);
      #1;
      chk("sys_reset", 16'h0001, {15'h0, sys_rst});
      @(posedge clk);
      cause <= 5'h00;
      wait_run();
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wait_run();
      chk("ladder", 16'h005A, {8'h00, ladder});
      chk("vector", RESET_VECTOR_LO, vec);
      rd_reg(ADDR_STAGE, 8'h00);
      rd_reg(ADDR_KEY, 8'h00);
      rd_reg(ADDR_CAUSE, 8'h00);
      rd_reg(16'h0F00, 8'h00);
      wr_reg(ADDR_STAGE, 8'hFF);
      rd_reg(ADDR_STAGE, 8'h07);
      wr_reg(ADDR_KEY, 8'h55);
      rd_reg(ADDR_KEY, 8'h00);
      // bench clock stands for high-speed run mode at gear divide four
      wr_reg(ADDR_KEY, KEY_PIN_DISABLE);
      rd_reg(ADDR_KEY, 8'h01);
      wr_reg(ADDR_KEY, KEY_OPTIONS);
      rd_reg(ADDR_KEY, 8'h07);
      chk("options", 16'h0003, {14'h0, opt_b, opt_a});
      // pin is ignored once its disable is committed
      @(posedge clk);
      ext_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("sys_reset", 16'h0000, {15'h0, sys_rst});
      @(posedge clk);
      ext_n <= 1'b1;
      // flags build up across internal resets
      for (int i = 0; i < 5; i++)
      begin
         hit(5'h01 << i);
         rd_reg(ADDR_CAUSE, (8'h02 << i) - 8'h01);
      end
      rd_reg(ADDR_KEY, 8'h01);
      rd_reg(ADDR_STAGE, 8'h00);
      @(posedge clk);
      trim_bad <= 1'b1;
      repeat (4) @(posedge clk);
      trim_bad <= 1'b0;
      rd_reg(ADDR_CAUSE, 8'h3F);
      wr_reg(ADDR_KEY, KEY_FLAG_CLEAR);
      rd_reg(ADDR_CAUSE, 8'h3F);
      wr_reg(ADDR_CAUSE, 8'h80);
      wr_reg(ADDR_KEY, KEY_FLAG_CLEAR);
      rd_reg(ADDR_CAUSE, 8'h00);
      // second cause lands inside the warm-up of the first
      @(posedge clk);
      cause <= 5'h04;
      repeat (6) @(posedge clk);
      cause <= 5'h00;
      repeat (6) @(posedge clk);
      hit(5'h08);
      chk("warmup", 16'h0001, {15'h0, n >= WARM});
      wr_reg(ADDR_KEY, KEY_FLAG_CLEAR);
      rd_reg(ADDR_CAUSE, 8'h0C);
      // power-on drops the disable, pin reset then works
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wait_run();
      rd_reg(ADDR_KEY, 8'h00);
      hit(5'h01);
      ext_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("sys_reset", 16'h0001, {15'h0, sys_rst});
      chk("vdet_off", 16'h0001, {15'h0, vdis});
      @(posedge clk);
      ext_n <= 1'b1;
      wait_run();
      rd_reg(ADDR_CAUSE, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
